// file: rtl/serial_slave_buffer_options.sv
`timescale 1ns/100ps
module serial_slave_buffer_options (
  input  wire logic        clk,      // System clock, 20 MHz.
  input  wire logic        resetn,   // Synchronous reset, active low.
  input  wire logic        psel,     // APB select.
  input  wire logic        penable,  // APB access phase.
  input  wire logic        pwrite,   // APB write direction.
  input  wire logic [7:0]  paddr,    // APB byte address.
  input  wire logic [31:0] pwdata,   // APB write data.
  output logic      [31:0] prdata,   // APB read data, registered.
  output logic             pready,   // APB ready, no wait states.
  output logic             pslverr,  // APB error on unmapped address.
  input  wire logic        link_clk, // Serial clock in, SPI clock or I2C clock line.
  input  wire logic        link_dat, // Serial data in, SPI data or I2C data line.
  input  wire logic        cs_n,     // SPI slave select, active low.
  output logic             sda_o,    // I2C data output level, always low.
  output logic             sda_oe,   // I2C data drive enable, high while pulling low.
  output logic             irq       // Level interrupt request.
);
  import serial_slave_buffer_options_pkg::*;
  // Every check below shares the system clock and is off while reset is held.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  typedef struct packed {
    logic       clk1, clk2, clkp;  // Link clock synchroniser and edge history.
    logic       dat1, dat2, datp;  // Link data synchroniser and edge history.
    logic       cs1, cs2;          // Slave select synchroniser.
    logic [7:0] shift;             // Incoming bits.
    logic [3:0] bitcnt;            // Bits taken in the current byte.
    logic       active;            // I2C transfer in progress.
    logic       ack_phase;         // I2C acknowledge slot in progress.
    logic       ack_ok;            // Last I2C byte earns an acknowledge.
    logic       drive;             // I2C data line pulled low.
    logic       ackt;              // Acknowledge-time status.
    logic [5:0] ctrl;              // Writable control bits.
    port_mode_t mode;              // Operating mode.
    logic [7:0] rbuf;              // Receive buffer.
    logic       bf;                // Buffer-full flag.
    logic       ov;                // Receive overflow flag.
    logic [2:0] ist;               // Sticky interrupt status.
    logic [2:0] imask;             // Interrupt mask.
    logic [31:0] rdata;            // Read data for the access phase.
  } state_t;

  state_t q, d;
  logic       clk_rise, clk_fall, start_evt, stop_evt, is_i2c;
  logic       byte_evt, accept, wr_acc, rd_acc, mapped;
  logic [7:0] new_byte;

  // Edge and condition detection only looks at the second and later stages.
  assign clk_rise  = q.clk2 & ~q.clkp;
  assign clk_fall  = ~q.clk2 & q.clkp;
  assign is_i2c    = q.mode[1];
  assign start_evt = is_i2c & q.clk2 & q.clkp & q.datp & ~q.dat2;
  assign stop_evt  = is_i2c & q.clk2 & q.clkp & ~q.datp & q.dat2;
  assign new_byte  = {q.shift[6:0], q.dat2};
  assign byte_evt  = clk_rise && q.bitcnt == LAST_BIT && (is_i2c ? q.active : ~q.cs2);
  assign wr_acc    = psel & penable & pwrite;
  assign rd_acc    = psel & penable & ~pwrite;

  // Address decode for the six mapped words.
  always_comb begin
    unique case (paddr)
      OFF_CONTROL_THREE, OFF_MODE, OFF_STATUS,
      OFF_RX_BUFFER, OFF_IRQ_STATUS, OFF_IRQ_MASK: mapped = 1'b1;
      default:                                       mapped = 1'b0;
    endcase
  end

  // Acceptance of a finished byte depends on mode and overwrite setting.
  always_comb begin
    unique case (q.mode)
      MODE_SPI_SLAVE:  accept = q.ctrl[CTL_OVERWRITE] | ~q.bf;
      MODE_SPI_MASTER: accept = ~q.bf;
      MODE_I2C_SLAVE,
      MODE_I2C_SLAVE_SS: accept = q.ctrl[CTL_OVERWRITE] | (~q.bf & ~q.ov);
    endcase
  end

  // Next-state logic: bus effects first, hardware sets last so a set wins.
  always_comb begin
    d = q;
    d.clk1 = link_clk;
    d.clk2 = q.clk1;
    d.clkp = q.clk2;
    d.dat1 = link_dat;
    d.dat2 = q.dat1;
    d.datp = q.dat2;
    d.cs1  = cs_n;
    d.cs2  = q.cs1;

    // Setup phase captures read data, so the access phase can answer at once.
    if (psel & ~penable & ~pwrite) begin
      unique case (paddr)
        OFF_CONTROL_THREE: d.rdata = {24'h0, q.ackt, 1'b0, q.ctrl};
        OFF_MODE:          d.rdata = {30'h0, q.mode};
        OFF_STATUS:        d.rdata = {30'h0, q.ov, q.bf};
        OFF_RX_BUFFER:     d.rdata = {24'h0, q.rbuf};
        OFF_IRQ_STATUS:    d.rdata = {29'h0, q.ist};
        OFF_IRQ_MASK:      d.rdata = {29'h0, q.imask};
        default:           d.rdata = 32'h0;
      endcase
    end

    // Register writes and read side effects take place at the access edge.
    if (wr_acc) begin
      unique case (paddr)
        OFF_CONTROL_THREE: d.ctrl = pwdata[5:0];
        OFF_MODE:          d.mode = port_mode_t'(pwdata[1:0]);
        OFF_STATUS:        d.ov = q.ov & ~pwdata[STS_OVERFLOW];
        OFF_IRQ_STATUS:    d.ist = q.ist & ~pwdata[2:0];
        OFF_IRQ_MASK:      d.imask = pwdata[2:0];
        default:           d.imask = q.imask;
      endcase
    end
    if (rd_acc && paddr == OFF_RX_BUFFER) begin
      d.bf = 1'b0;
    end

    if (!is_i2c) begin
      // SPI: deselect aborts a partial byte; bits shift on the rising clock.
      d.active    = 1'b0;
      d.drive     = 1'b0;
      d.ack_phase = 1'b0;
      if (q.cs2) begin
        d.bitcnt = 4'h0;
      end else if (clk_rise) begin
        d.shift  = new_byte;
        d.bitcnt = (q.bitcnt == LAST_BIT) ? 4'h0 : q.bitcnt + 4'h1;
      end
    end else if (start_evt) begin
      // Start or repeated start restarts byte framing.
      d.active    = 1'b1;
      d.bitcnt    = 4'h0;
      d.drive     = 1'b0;
      d.ack_phase = 1'b0;
    end else if (stop_evt) begin
      d.active    = 1'b0;
      d.drive     = 1'b0;
      d.ack_phase = 1'b0;
    end else if (q.active) begin
      if (clk_rise && q.bitcnt < ACK_SLOT) begin
        d.shift  = new_byte;
        d.bitcnt = q.bitcnt + 4'h1;
      end else if (clk_rise) begin
        // Ninth rising edge ends the acknowledge-time window.
        d.ackt   = 1'b0;
        d.bitcnt = 4'h0;
      end else if (clk_fall && q.bitcnt == ACK_SLOT && !q.ack_phase) begin
        // Eighth falling edge opens the acknowledge slot.
        d.ack_phase = 1'b1;
        d.drive     = q.ack_ok;
        d.ackt      = 1'b1;
      end else if (clk_fall && q.ack_phase && q.bitcnt == 4'h0) begin
        d.ack_phase = 1'b0;
        d.drive     = 1'b0;
      end
    end

    // Finished byte: load the buffer or flag an overflow.
    if (byte_evt) begin
      d.ack_ok = accept;
      if (accept) begin
        d.rbuf     = new_byte;
        d.bf       = 1'b1;
        d.ist[IRQ_BYTE] = 1'b1;
        if (q.bf && q.mode == MODE_SPI_SLAVE) begin
          // Overwrite keeps the newest byte, but software still learns that one was lost.
          d.ov = 1'b1;
          d.ist[IRQ_OVERFLOW] = 1'b1;
        end
      end else if (q.bf) begin
        d.ov       = 1'b1;
        d.ist[IRQ_OVERFLOW] = 1'b1;
      end
    end

    // Start detection interrupts; the start/stop slave mode always reports.
    if (start_evt && (q.ctrl[CTL_START_IRQ] || q.mode == MODE_I2C_SLAVE_SS)) begin
      d.ist[IRQ_START] = 1'b1;
    end

    // Without a hold enable the acknowledge-time flag stays low.
    if (!(d.ctrl[CTL_ADDR_HOLD] | d.ctrl[CTL_DATA_HOLD])) begin
      d.ackt = 1'b0;
    end
  end

  // Single state register with synchronous reset.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= '{clk1: 1'b0, clk2: 1'b0, clkp: 1'b0, dat1: 1'b1, dat2: 1'b1, datp: 1'b1,
             cs1: 1'b1, cs2: 1'b1, shift: 8'h00, bitcnt: 4'h0, active: 1'b0,
             ack_phase: 1'b0, ack_ok: 1'b0, drive: 1'b0, ackt: 1'b0, ctrl: CTL_RESET,
             mode: MODE_SPI_SLAVE, rbuf: 8'h00, bf: 1'b0, ov: 1'b0, ist: IRQ_RESET,
             imask: IRQ_RESET, rdata: 32'h0};
    end else begin
      q <= d;
    end
  end

  // Outputs. Zero wait states keep the bus simple at this clock rate.
  assign prdata  = q.rdata;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign sda_o   = 1'b0;
  assign sda_oe  = q.drive;
  assign irq     = |(q.ist & q.imask);

  sequence s_loaded;
    q.bf && q.rbuf == $past(new_byte);
  endsequence

  sequence s_held;
    q.ov && q.rbuf == $past(q.rbuf);
  endsequence

  sequence s_ack_driven;
    1'b1 ##[1:300] sda_oe;
  endsequence

  AST_SPI_OVERWRITE: assert property (
    byte_evt && q.mode == MODE_SPI_SLAVE && q.ctrl[CTL_OVERWRITE] |=> s_loaded)
    else $error("SPI overwrite did not load the byte");

  AST_SPI_OVERFLOW: assert property (
    byte_evt && q.mode == MODE_SPI_SLAVE && !q.ctrl[CTL_OVERWRITE] && q.bf |=> s_held)
    else $error("SPI overflow not flagged or buffer changed");

  AST_I2C_OVERWRITE: assert property (
    byte_evt && is_i2c && q.ctrl[CTL_OVERWRITE] && !start_evt
    ##1 (q.active && !start_evt && !stop_evt) [*1]
    |-> s_loaded ##0 s_ack_driven)
    else $error("I2C overwrite did not load and acknowledge");

  AST_START_IRQ: assert property (
    start_evt && q.ctrl[CTL_START_IRQ] |=> q.ist[IRQ_START])
    else $error("Start did not raise interrupt status");

  AST_NO_START_IRQ: assert property (
    start_evt && !q.ctrl[CTL_START_IRQ] && q.mode != MODE_I2C_SLAVE_SS
    && !q.ist[IRQ_START] |=> !q.ist[IRQ_START])
    else $error("Start interrupt raised while disabled");

  AST_ACKT_GATED: assert property (
    !(q.ctrl[CTL_ADDR_HOLD] | q.ctrl[CTL_DATA_HOLD]) |-> !q.ackt)
    else $error("Ack-time flag active without hold enable");

  AST_MASTER_NORMAL: assert property (
    byte_evt && q.mode == MODE_SPI_MASTER && q.bf |=> s_held)
    else $error("SPI master overwrote a full buffer");

  // Eighth falling edge of a framed byte, with no condition on the bus.
  sequence s_ack_open;
    clk_fall && is_i2c && q.active && q.bitcnt == ACK_SLOT && !q.ack_phase
    && !start_evt && !stop_evt;
  endsequence

  // Ninth rising edge, which ends the acknowledge-time window.
  sequence s_ack_close;
    clk_rise && is_i2c && q.active && q.bitcnt == ACK_SLOT && !start_evt && !stop_evt;
  endsequence

  AST_ACKT_SET: assert property (
    s_ack_open ##0 ((q.ctrl[CTL_ADDR_HOLD] | q.ctrl[CTL_DATA_HOLD]) && !wr_acc) |=> q.ackt)
    else $error("Ack-time flag not set at the acknowledge slot");

  AST_ACKT_CLEAR: assert property (
    s_ack_close |=> !q.ackt)
    else $error("Ack-time flag not cleared after the acknowledge slot");

  AST_I2C_REFUSE: assert property (
    byte_evt && is_i2c && !q.ctrl[CTL_OVERWRITE] && (q.bf || q.ov)
    |=> q.rbuf == $past(q.rbuf) && !q.ack_ok)
    else $error("I2C byte taken while the buffer was blocked");

  AST_SPI_OVERWRITE_LOST: assert property (
    byte_evt && q.mode == MODE_SPI_SLAVE && q.ctrl[CTL_OVERWRITE] && q.bf |=> q.ov)
    else $error("SPI overwrite of a full buffer not reported");

  AST_START_IRQ_FORCED: assert property (
    start_evt && q.mode == MODE_I2C_SLAVE_SS |=> q.ist[IRQ_START])
    else $error("Start in the start and stop mode did not raise interrupt status");

  AST_ACK_RELEASE: assert property (
    clk_fall && is_i2c && q.active && q.ack_phase && q.bitcnt == 4'h0
    && !start_evt && !stop_evt |=> !sda_oe)
    else $error("Acknowledge drive not released after the slot");

  AST_MASTER_LOADS: assert property (
    byte_evt && q.mode == MODE_SPI_MASTER && !q.bf |=> s_loaded)
    else $error("SPI master did not load a byte into an empty buffer");

  // A buffer read frees the buffer unless a new byte lands in the same cycle.
  AST_BF_READ_CLEAR: assert property (
    rd_acc && paddr == OFF_RX_BUFFER && !byte_evt |=> !q.bf)
    else $error("Buffer-full flag not cleared by a buffer read");

  // SPI modes release the data line from their second cycle on, so a stale acknowledge lasts at most one cycle.
  AST_SPI_NO_DRIVE: assert property (
    !is_i2c |=> !sda_oe)
    else $error("Data line driven in an SPI mode");

endmodule : serial_slave_buffer_options

// file: rtl/serial_slave_buffer_options_pkg.sv
package serial_slave_buffer_options_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFF_CONTROL_THREE = 8'h00;
  localparam logic [7:0] OFF_MODE          = 8'h04;
  localparam logic [7:0] OFF_STATUS        = 8'h08;
  localparam logic [7:0] OFF_RX_BUFFER     = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STATUS    = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK      = 8'h14;

  // Field positions of serial_port_control_three.
  localparam int CTL_ACK_TIME    = 7;
  localparam int CTL_START_IRQ   = 5;
  localparam int CTL_OVERWRITE   = 4;
  localparam int CTL_SDA_HOLD    = 3;
  localparam int CTL_SLV_COLL    = 2;
  localparam int CTL_ADDR_HOLD   = 1;
  localparam int CTL_DATA_HOLD   = 0;
  localparam logic [5:0] CTL_RESET = 6'h00;

  // Field positions of the status register.
  localparam int STS_BUFFER_FULL = 0;
  localparam int STS_OVERFLOW    = 1;

  // Interrupt status and mask bits.
  localparam int IRQ_START    = 0;
  localparam int IRQ_BYTE     = 1;
  localparam int IRQ_OVERFLOW = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // Bit count of the last bit in a byte, and the bit count that marks the acknowledge slot.
  localparam logic [3:0] LAST_BIT  = 4'h7;
  localparam logic [3:0] ACK_SLOT  = 4'h8;

  // Serial port operating modes.
  typedef enum logic [1:0] {
    MODE_SPI_SLAVE    = 2'b00,
    MODE_SPI_MASTER   = 2'b01,
    MODE_I2C_SLAVE    = 2'b10,
    MODE_I2C_SLAVE_SS = 2'b11
  } port_mode_t;

endpackage : serial_slave_buffer_options_pkg

// file: testbench/link_master.sv
`timescale 1ns/100ps
// Behavioural serial bus master at the far side of the link.
// Its clock stands still between frames: low when idle in SPI, high after an I2C stop.
// Every change after the time-zero idle levels is a non-blocking assignment, so none races the device's clock edge.
module link_master (
  output logic     link_clk, // Serial clock towards the device.
  output logic     sda_m,    // Data level driven by the master, high when released.
  output logic     cs_n,     // SPI slave select, active low.
  input wire logic sda_line  // Resolved data line, seen with the device's pull-down.
);
  // Idle levels at time zero.
  initial begin
    link_clk = 1'b0;
    sda_m = 1'b1;
    cs_n = 1'b1;
  end

  // One SPI byte, MSB first, each bit set up a quarter period before its rising edge.
  task automatic spi_byte(input logic [7:0] b);
    cs_n <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sda_m <= b[i];
      #100 link_clk <= 1'b1;
      #200 link_clk <= 1'b0;
      #100;
    end
    cs_n <= 1'b1;
    // Once deselected the line shows the inverse, so a stale bit is never mistaken for data.
    sda_m <= ~sda_m;
    #100;
  endtask : spi_byte

  // Start or repeated start: data falls while the clock is high.
  task automatic i2c_start();
    sda_m <= 1'b1;
    #100 link_clk <= 1'b1;
    #100 sda_m <= 1'b0;
    #100 link_clk <= 1'b0;
    #100;
  endtask : i2c_start

  // Eight data bits, then the acknowledge slot, sampled while the clock is high.
  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_m <= b[i];
      #100 link_clk <= 1'b1;
      #200 link_clk <= 1'b0;
      #100;
    end
    sda_m <= 1'b1;
    #100 link_clk <= 1'b1;
    #100 ack = ~sda_line;
    #100 link_clk <= 1'b0;
    #100;
  endtask : i2c_byte

  // Stop: data rises while the clock is high, leaving the bus idle.
  task automatic i2c_stop();
    sda_m <= 1'b0;
    #100 link_clk <= 1'b1;
    #100 sda_m <= 1'b1;
    #100;
  endtask : i2c_stop
endmodule : link_master

// file: testbench/serial_slave_buffer_options_tb.sv
`timescale 1ns/100ps
// Self-checking bench: APB master, integer model of the receive path, serial master.
module serial_slave_buffer_options_tb;
  import serial_slave_buffer_options_pkg::*;
  logic        clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, slv, link_clk, link_dat, cs_n, sda_m, sda_o, sda_oe, irq, ack;
  int          err_count = 0, cmp_count = 0, cyc = 0, bf = 0, ov = 0, rbuf = 0, seed = 61;

  // Open-drain data line: wired-and of the master and the level the device drives.
  assign link_dat = sda_m & (~sda_oe | sda_o);
  always #25 clk = ~clk;

  serial_slave_buffer_options u_dut (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_clk(link_clk), .link_dat(link_dat),
    .cs_n(cs_n), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
  link_master u_master (.link_clk(link_clk), .sda_m(sda_m), .cs_n(cs_n), .sda_line(link_dat));

  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // One APB transfer; the request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees ready.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(r & m, e & m);
  endtask : rdc

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // A hung handshake or link ends the run as a failure.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    int m, o, k, b;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset values, read-only bits and an unmapped address.
    rdc(OFF_CONTROL_THREE, 32'hff, 32'h0);
    rdc(OFF_IRQ_MASK, 32'h7, 32'h0);
    apb(1'b1, 8'h18, 32'hffffffff);
    chk(slv, 1'b1);
    apb(1'b1, OFF_CONTROL_THREE, 32'hff);
    rdc(OFF_CONTROL_THREE, 32'hff, 32'h3f);
    apb(1'b1, OFF_IRQ_MASK, 32'h1);
    // SPI slave and master, overwrite off and on, second byte lands while the buffer is full.
    for (m = 0; m < 2; m++) for (o = 0; o < 2; o++) begin
      apb(1'b1, OFF_MODE, m);
      apb(1'b1, OFF_CONTROL_THREE, o ? 32'h10 : 32'h0);
      apb(1'b1, OFF_STATUS, 32'h2);
      apb(1'b0, OFF_RX_BUFFER, 32'h0);
      bf = 0;
      ov = 0;
      repeat (2) begin
        b = rnd() & 8'hff;
        u_master.spi_byte(b[7:0]);
        // A byte that meets a full buffer is always reported lost, even when it overwrites.
        if (bf == 1) ov = 1;
        if ((o == 1 && m == 0) || bf == 0) begin
          rbuf = b;
          bf = 1;
        end
        repeat (4) @(posedge clk);
        rdc(OFF_STATUS, 32'h3, {ov[0], bf[0]});
      end
      rdc(OFF_RX_BUFFER, 32'hff, rbuf);
    end
    // A second reset in mid-run clears the flags and settings left by the SPI passes.
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(OFF_STATUS, 32'h3, 32'h0);
    rdc(OFF_CONTROL_THREE, 32'hff, 32'h0);
    apb(1'b1, OFF_IRQ_MASK, 32'h1);
    // I2C: start interrupt off, on, and forced by mode 3; accept, refuse, then overwrite.
    bf = 0;
    ov = 0;
    for (k = 0; k < 3; k++) begin
      apb(1'b1, OFF_MODE, (k == 2) ? 32'h3 : 32'h2);
      apb(1'b1, OFF_CONTROL_THREE, (k == 1 ? 32'h20 : 32'h0) | (k == 2 ? 32'h10 : 32'h0) | 32'h3);
      apb(1'b1, OFF_IRQ_STATUS, 32'h7);
      u_master.i2c_start();
      repeat (4) @(posedge clk);
      chk(irq, k != 0);
      rdc(OFF_IRQ_STATUS, 32'h1, k != 0);
      b = rnd() & 8'hff;
      u_master.i2c_byte(b[7:0], ack);
      o = (k == 2) || (bf == 0 && ov == 0);
      if (o) begin
        rbuf = b;
        bf = 1;
      end else if (bf) ov = 1;
      chk(ack, o[0]);
      u_master.i2c_stop();
      repeat (4) @(posedge clk);
      rdc(OFF_STATUS, 32'h3, {ov[0], bf[0]});
    end
    rdc(OFF_RX_BUFFER, 32'hff, rbuf);
    wrap_up();
  end
endmodule : serial_slave_buffer_options_tb
